// [core/pbs_buf2.sv]
`timescale 1ns/1ns

module pbs_buf2 #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);

    logic [W-1:0] ent_q [2];
    logic [W-1:0] ent_d [2];
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = ent_q[0];

    always_comb begin
        logic push;
        logic pop;
        push = in_valid_i & in_ready_o;
        pop = out_valid_o & out_ready_i;
        ent_d = ent_q;
        cnt_d = cnt_q;
        if (pop) begin
            ent_d[0] = ent_q[1];
        end
        if (push) begin
            if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
                ent_d[0] = in_data_i;
            end else begin
                ent_d[1] = in_data_i;
            end
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_d;
        end
        ent_q <= ent_d;
    end

endmodule

// [core/pbs_core.sv]
`timescale 1ns/1ns
`include "pbs_params.svh"

// Operation
// - Burst order high: low address bits are start XOR step 0..3.
// - Burst order low: low address bits count up modulo four.
// - Unselected load deselects; advance continues deselect after one, or from idle after reset.
// - Selected load with write enable high latches address, starts read.
// - Advance during read steps to next address, chip select ignored.
// - Output enable high gives dummy read: addresses step, no drive.
// - Selected load, write enable low, bytes on: latch address, start write.
// - Advance in write steps address; no byte enables aborts that beat.
// - Clock enable inactive: ignore inputs, hold pipeline registers and address; buffered writes still commit.
// - Each active byte enable writes its lane; none active aborts.
// - Second half uses its own four byte enables, same decoding.
// - Chip selected only when both low selects low, high select high.
// - Output enable and sleep override the clocked command decode.
// - Two-bit burst counter wraps after four beats, no carry upward.
// - Read data appears on outputs at second edge after address.
// - Sleep four cycles after request (two synchroniser, two entry), state kept; wake also two plus two cycles.
module pbs_core
    import pbs_pkg::*;
#(
    parameter int AW = `PBS_ADDR_W,
    parameter int LANES = `PBS_LANES,
    parameter int LW = `PBS_LANE_W
) (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    // Synchronous command pins
    input wire logic [AW-1:0] ADDR_I,
    input wire logic CHIP_SELECT_ONE_N_I,
    input wire logic CHIP_SELECT_TWO_N_I,
    input wire logic CHIP_SELECT_HIGH_I,
    input wire logic ADVANCE_OR_LOAD_I,
    input wire logic WRITE_ENABLE_N_I,
    input wire logic [LANES-1:0] BYTE_WRITE_ENABLE_N_I,
    input wire logic CLOCK_ENABLE_N_I,
    // Asynchronous and static pins
    input wire logic OUTPUT_ENABLE_N_I,
    input wire logic SLEEP_REQUEST_I,
    input wire logic BURST_ORDER_SELECT_N_I,
    // Data bus
    input wire logic [LANES*LW-1:0] DQ_I,
    output logic [LANES*LW-1:0] DQ_O,
    output logic DQ_OE_O,
    // Status
    output logic SLEEP_ACTIVE_O
);

    localparam int DW = LANES * LW;
    localparam int BW = AW + LANES + DW;
    localparam int DEPTH = 1 << AW;

    ////////////////////////////////////////////////////////////////////
    // Synchronisers for the pins that are not clocked by the host

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic oe_n_s;
    logic sleep_s;
    logic lbo_s;

    always_ff @(posedge MCLK_I) begin
        meta_q <= {OUTPUT_ENABLE_N_I, SLEEP_REQUEST_I, BURST_ORDER_SELECT_N_I};
        sync_q <= meta_q;
    end

    assign oe_n_s = sync_q[2];
    assign sleep_s = sync_q[1];
    assign lbo_s = sync_q[0];

    ////////////////////////////////////////////////////////////////////
    // Sleep sequencer

    logic asleep_q;
    logic asleep_d;
    logic [1:0] slp_cnt_q;
    logic [1:0] slp_cnt_d;

    always_comb begin
        asleep_d = asleep_q;
        slp_cnt_d = `PBS_SLEEP_CNT_RST;
        if (sleep_s != asleep_q) begin
            slp_cnt_d = slp_cnt_q + 2'h1;
            // Enter after two cycles, leave after two wake cycles
            if (!asleep_q && slp_cnt_q == 2'(`PBS_SLEEP_ENTER_CYC - 1)) begin
                asleep_d = 1'b1;
                slp_cnt_d = `PBS_SLEEP_CNT_RST;
            end else if (asleep_q && slp_cnt_q == 2'(`PBS_WAKE_CYC - 1)) begin
                asleep_d = 1'b0;
                slp_cnt_d = `PBS_SLEEP_CNT_RST;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            asleep_q <= 1'b0;
            slp_cnt_q <= `PBS_SLEEP_CNT_RST;
        end else begin
            asleep_q <= asleep_d;
            slp_cnt_q <= slp_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command decode and burst address

    logic buf_in_ready;
    logic go;
    logic sel;
    logic any_be;

    pbs_state_t state_q;
    pbs_state_t state_d;
    logic [AW-1:0] base_q;
    logic [AW-1:0] base_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic s1_rd_q;
    logic s1_rd_d;
    logic s1_wr_q;
    logic s1_wr_d;
    logic [AW-1:0] s1_addr_q;
    logic [AW-1:0] s1_addr_d;
    logic [LANES-1:0] s1_be_q;
    logic [LANES-1:0] s1_be_d;
    logic s2_rd_q;
    logic s2_rd_d;
    logic s2_wr_q;
    logic s2_wr_d;
    logic [AW-1:0] s2_addr_q;
    logic [AW-1:0] s2_addr_d;
    logic [LANES-1:0] s2_be_q;
    logic [LANES-1:0] s2_be_d;

    function automatic logic [AW-1:0] burst_addr(
        input logic [AW-1:0] base,
        input logic [1:0] step,
        input logic lbo
    );
        logic [1:0] lo;
        lo = lbo ? (base[1:0] ^ step)
                 : (base[1:0] + step);
        return {base[AW-1:2], lo};
    endfunction

    // Sleep gates the inputs; a full write buffer stalls the pipe too
    assign go = ~CLOCK_ENABLE_N_I & ~asleep_q & buf_in_ready;
    assign sel = ~CHIP_SELECT_ONE_N_I & ~CHIP_SELECT_TWO_N_I
               & CHIP_SELECT_HIGH_I;
    assign any_be = ~&BYTE_WRITE_ENABLE_N_I;

    always_comb begin
        state_d = state_q;
        base_d = base_q;
        cnt_d = cnt_q;
        s1_rd_d = s1_rd_q;
        s1_wr_d = s1_wr_q;
        s1_addr_d = s1_addr_q;
        s1_be_d = s1_be_q;
        s2_rd_d = s2_rd_q;
        s2_wr_d = s2_wr_q;
        s2_addr_d = s2_addr_q;
        s2_be_d = s2_be_q;
        if (go) begin
            s1_rd_d = 1'b0;
            s1_wr_d = 1'b0;
            s1_be_d = ~BYTE_WRITE_ENABLE_N_I;
            s2_rd_d = s1_rd_q;
            s2_wr_d = s1_wr_q;
            s2_addr_d = s1_addr_q;
            s2_be_d = s1_be_q;
            if (!ADVANCE_OR_LOAD_I) begin
                base_d = ADDR_I;
                cnt_d = `PBS_BURST_CNT_RST;
                s1_addr_d = ADDR_I;
                if (!sel) begin
                    state_d = PBS_DESEL;
                end else if (WRITE_ENABLE_N_I) begin
                    state_d = PBS_READ;
                    s1_rd_d = 1'b1;
                end else begin
                    state_d = PBS_WRITE;
                    s1_wr_d = any_be;
                end
            end else begin
                case (state_q)
                    PBS_READ: begin
                        cnt_d = cnt_q + 2'h1;
                        s1_addr_d = burst_addr(base_q, cnt_d, lbo_s);
                        s1_rd_d = 1'b1;
                    end
                    PBS_WRITE: begin
                        cnt_d = cnt_q + 2'h1;
                        s1_addr_d = burst_addr(base_q, cnt_d, lbo_s);
                        s1_wr_d = any_be;
                    end
                    // Continue deselect after a prior deselect, or from IDLE after reset
                    default: begin
                        state_d = state_q;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            state_q <= PBS_IDLE;
            base_q <= '0;
            cnt_q <= `PBS_BURST_CNT_RST;
            s1_rd_q <= 1'b0;
            s1_wr_q <= 1'b0;
            s1_addr_q <= '0;
            s1_be_q <= '0;
            s2_rd_q <= 1'b0;
            s2_wr_q <= 1'b0;
            s2_addr_q <= '0;
            s2_be_q <= '0;
        end else begin
            state_q <= state_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
            s1_rd_q <= s1_rd_d;
            s1_wr_q <= s1_wr_d;
            s1_addr_q <= s1_addr_d;
            s1_be_q <= s1_be_d;
            s2_rd_q <= s2_rd_d;
            s2_wr_q <= s2_wr_d;
            s2_addr_q <= s2_addr_d;
            s2_be_q <= s2_be_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write data buffer: late data joins its address two edges on

    logic buf_out_valid;
    logic buf_out_ready;
    logic [BW-1:0] buf_out_data;
    logic [AW-1:0] wr_addr;
    logic [LANES-1:0] wr_be;
    logic [DW-1:0] wr_data;
    logic commit;

    // Array is frozen while asleep, so buffered writes wait there
    assign buf_out_ready = ~asleep_q;
    assign commit = buf_out_valid & buf_out_ready;
    assign {wr_addr, wr_be, wr_data} = buf_out_data;

    pbs_buf2 #(
        .W(BW)
    ) u_wbuf (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .in_valid_i(go & s2_wr_q),
        .in_ready_o(buf_in_ready),
        .in_data_i({s2_addr_q, s2_be_q, DQ_I}),
        .out_valid_o(buf_out_valid),
        .out_ready_i(buf_out_ready),
        .out_data_o(buf_out_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Array lanes, read capture and output register

    logic [DW-1:0] rd_q;

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LW-1:0] mem_q [DEPTH];

        always_ff @(posedge MCLK_I) begin
            // Parity bit rides with its data bits
            if (commit && wr_be[l]) begin
                mem_q[wr_addr] <= wr_data[l*LW +: LW];
            end
            // Internal capture one edge after the address
            if (go) begin
                rd_q[l*LW +: LW] <= mem_q[s1_addr_q];
            end
        end
    end

    logic out_v_q;
    logic out_v_d;
    logic [DW-1:0] dq_d;
    logic dq_oe_d;

    always_comb begin
        out_v_d = out_v_q;
        dq_d = DQ_O;
        if (go) begin
            out_v_d = s2_rd_q;
            dq_d = rd_q;
        end
        // Dummy read when output enable is high
        dq_oe_d = out_v_d & ~oe_n_s & ~asleep_d;
    end

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            out_v_q <= 1'b0;
            DQ_O <= '0;
            DQ_OE_O <= 1'b0;
            SLEEP_ACTIVE_O <= 1'b0;
        end else begin
            out_v_q <= out_v_d;
            DQ_O <= dq_d;
            DQ_OE_O <= dq_oe_d;
            SLEEP_ACTIVE_O <= asleep_d;
        end
    end

endmodule

// [shared/pbs_params.svh]
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

// Array shape
`define PBS_ADDR_W 19
`define PBS_LANES 8
`define PBS_LANE_W 9
`define PBS_BURST_W 2

// Timing counts, in clock cycles
`define PBS_SLEEP_ENTER_CYC 2
`define PBS_WAKE_CYC 2

// Reset values
`define PBS_SLEEP_CNT_RST 2'h0
`define PBS_BURST_CNT_RST 2'h0

`endif

// [shared/pbs_pkg.sv]
package pbs_pkg;

    // Burst sequencer state; IDLE means nothing executed since reset
    typedef enum logic [1:0] {
        PBS_IDLE,
        PBS_DESEL,
        PBS_READ,
        PBS_WRITE
    } pbs_state_t;

endpackage

// [verif/pbs_core_sva.sv]
`timescale 1ns/1ns

module pbs_core_chk #(
    parameter int LANES = 8,
    parameter int LW = 9
) (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    // Command pins
    input wire logic CHIP_SELECT_ONE_N_I,
    input wire logic CHIP_SELECT_TWO_N_I,
    input wire logic CHIP_SELECT_HIGH_I,
    input wire logic ADVANCE_OR_LOAD_I,
    input wire logic WRITE_ENABLE_N_I,
    input wire logic CLOCK_ENABLE_N_I,
    input wire logic OUTPUT_ENABLE_N_I,
    input wire logic SLEEP_REQUEST_I,
    // Outputs
    input wire logic [LANES*LW-1:0] DQ_O,
    input wire logic DQ_OE_O,
    input wire logic SLEEP_ACTIVE_O
);
    logic [2:0] oe_cnt_q;
    logic [2:0] oe_cnt_d;
    wire logic run = !CLOCK_ENABLE_N_I && !SLEEP_ACTIVE_O && !SLEEP_REQUEST_I;
    wire logic sel = !CHIP_SELECT_ONE_N_I && !CHIP_SELECT_TWO_N_I &&
        CHIP_SELECT_HIGH_I;
    wire logic ld = run && !ADVANCE_OR_LOAD_I;
    // Pin level at the load edge is what the output stage sees two edges on
    wire logic rd_ld = ld && sel && WRITE_ENABLE_N_I && oe_cnt_q >= 3'h4 &&
        !OUTPUT_ENABLE_N_I;
    wire logic wr_ld = ld && sel && !WRITE_ENABLE_N_I;

    // Output enable pin needs several edges to settle
    always_comb begin
        oe_cnt_d = oe_cnt_q;
        if (OUTPUT_ENABLE_N_I)
            oe_cnt_d = 3'h0;
        else if (oe_cnt_q != 3'h7)
            oe_cnt_d = oe_cnt_q + 3'h1;
    end
    always_ff @(posedge MCLK_I) begin
        oe_cnt_q <= SYS_RST_I ? 3'h0 : oe_cnt_d;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I);

    chk_ce_hold: assert property (
        CLOCK_ENABLE_N_I |=> $stable(DQ_O)) else $error("data moved");
    chk_oe_dummy: assert property (
        (OUTPUT_ENABLE_N_I && !CLOCK_ENABLE_N_I)[*4] |=> !DQ_OE_O)
        else $error("drive under oe high");
    chk_sleep_in: assert property (
        SLEEP_REQUEST_I[*6] |=> SLEEP_ACTIVE_O) else $error("no sleep");
    chk_sleep_out: assert property (
        !SLEEP_REQUEST_I[*6] |=> !SLEEP_ACTIVE_O) else $error("no wake");
    chk_sleep_late: assert property (
        // Two synchroniser edges, then two entry cycles
        $rose(SLEEP_ACTIVE_O) |-> $past(SLEEP_REQUEST_I, 3) &&
        $past(SLEEP_REQUEST_I, 4))
        else $error("sleep too early");
    chk_rd_drive: assert property (
        rd_ld ##1 (run && !OUTPUT_ENABLE_N_I)[*2] |=> DQ_OE_O)
        else $error("read not driven");
    chk_wr_quiet: assert property (
        wr_ld ##1 run[*2] |=> !DQ_OE_O) else $error("drive in write");
    chk_desel_quiet: assert property (
        ld && !sel ##1 run[*2] |=> !DQ_OE_O) else $error("drive unselected");

    cover property (rd_ld);
    cover property (wr_ld);
    cover property ($rose(SLEEP_ACTIVE_O));
endmodule

bind pbs_core pbs_core_chk #(.LANES(LANES), .LW(LW)) u_chk (
    .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
    .CHIP_SELECT_ONE_N_I(CHIP_SELECT_ONE_N_I),
    .CHIP_SELECT_TWO_N_I(CHIP_SELECT_TWO_N_I),
    .CHIP_SELECT_HIGH_I(CHIP_SELECT_HIGH_I),
    .ADVANCE_OR_LOAD_I(ADVANCE_OR_LOAD_I),
    .WRITE_ENABLE_N_I(WRITE_ENABLE_N_I),
    .CLOCK_ENABLE_N_I(CLOCK_ENABLE_N_I),
    .OUTPUT_ENABLE_N_I(OUTPUT_ENABLE_N_I),
    .SLEEP_REQUEST_I(SLEEP_REQUEST_I), .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O),
    .SLEEP_ACTIVE_O(SLEEP_ACTIVE_O));

// [verif/pbs_host.sv]
`timescale 1ns/1ns

module pbs_host (
    // Clock and beat request from the bench
    input wire logic clk_i,
    input wire logic ce_n_i,
    input wire logic wr_beat_i,
    input wire logic [71:0] wdat_i,
    // Data pins toward the memory
    output logic [71:0] dq_o
);
    logic v1_q = 1'b0;
    logic v2_q = 1'b0;
    logic [71:0] d1_q = '0;
    logic [71:0] d2_q = '0;
    logic [71:0] last_q = '0;

    // Late write: data two enabled edges after its command
    always_ff @(posedge clk_i) begin
        if (!ce_n_i) begin
            v1_q <= wr_beat_i;
            d1_q <= wdat_i;
            v2_q <= v1_q;
            d2_q <= d1_q;
        end
        last_q <= dq_o;
    end

    // Idle bus toggles so a stale word is never seen as valid
    assign dq_o = v2_q ? d2_q : ~last_q;
endmodule

// [verif/tb.sv]
`timescale 1ns/1ns
`include "pbs_params.svh"

module tb;
    localparam logic [2:0] SEL = 3'h1;
    localparam logic [2:0] DES = 3'h5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] a = '0;
    logic cs1n = 1'b1, cs2n = 1'b1, csh = 1'b0, advance_or_load = 1'b0, wen = 1'b1;
    logic cen = 1'b0, oen = 1'b0, slp = 1'b0, wb = 1'b0;
    logic lbo = 1'b1; // Always driven, never floating
    logic [7:0] bw = 8'hFF;
    logic [71:0] wd = '0;
    logic [71:0] dqi, dqo;
    logic oe, sa;
    logic [71:0] mem [64];
    logic [2:0] bad [3] = '{3'h5, 3'h3, 3'h0};
    int n_mismatch = 0;
    int num_checks = 0;

    always #20 clk = ~clk;

    pbs_host u_host (.clk_i(clk), .ce_n_i(cen), .wr_beat_i(wb),
        .wdat_i(wd), .dq_o(dqi));
    pbs_core #(.AW(6)) dut (.MCLK_I(clk), .SYS_RST_I(rst), .ADDR_I(a),
        .CHIP_SELECT_ONE_N_I(cs1n), .CHIP_SELECT_TWO_N_I(cs2n),
        .CHIP_SELECT_HIGH_I(csh), .ADVANCE_OR_LOAD_I(advance_or_load),
        .WRITE_ENABLE_N_I(wen), .BYTE_WRITE_ENABLE_N_I(bw),
        .CLOCK_ENABLE_N_I(cen), .OUTPUT_ENABLE_N_I(oen),
        .SLEEP_REQUEST_I(slp), .BURST_ORDER_SELECT_N_I(lbo),
        .DQ_I(dqi), .DQ_O(dqo), .DQ_OE_O(oe), .SLEEP_ACTIVE_O(sa));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [71:0] e, s);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask

    function automatic logic [5:0] nxt(input logic [5:0] b, input int k);
        logic [1:0] s;
        s = lbo ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k);
        return {b[5:2], s};
    endfunction

    // One command per edge, launched at the falling edge
    task automatic cyc(input logic ad, w, input logic [2:0] sv,
        input logic [5:0] x, input logic b = 1'b0,
        input logic [7:0] m = 8'hFF, input logic [71:0] d = '0);
        @(negedge clk);
        advance_or_load = ad;
        wen = w;
        {cs1n, cs2n, csh} = sv;
        a = x;
        wb = b;
        bw = m;
        wd = d;
    endtask

    task automatic wr_burst(input logic [5:0] b, input logic [2:0] sd,
        input logic [7:0] m);
        logic [5:0] x;
        for (int k = 0; k < 4; k++) begin
            x = nxt(b, k);
            cyc(k > 0, 1'b0, SEL, b, 1'b1, m, {8{sd, x}});
            for (int l = 0; l < 8; l++)
                if (!m[l]) mem[x][9*l+:9] = {sd, x};
        end
        // Let the late write pipe drain before any read
        repeat (4) cyc(1'b0, 1'b1, DES, '0);
    endtask

    task automatic rd_burst(input logic [5:0] b, input logic stall);
        for (int k = 0; k < 7; k++) begin
            if (stall && k == 2) begin
                cen = 1'b1;
                repeat (3) @(negedge clk);
                cen = 1'b0;
            end
            // Advance beats unselected: select is ignored mid-burst
            cyc(k > 0 && k < 4, 1'b1, k == 0 ? SEL : DES, b);
            if (k > 2 && oen)
                chk("dummy drive", 1'h0, oe);
            if (k > 2 && !oen) begin
                chk("read data", mem[nxt(b, k - 3)], dqo);
                chk("read drive", 1'h1, oe);
            end
        end
    endtask

    task automatic wait_sa(input logic v);
        int n = 0;
        int exp_n;
        // Two synchroniser edges before the sequencer counts
        exp_n = 2 + (v ? `PBS_SLEEP_ENTER_CYC : `PBS_WAKE_CYC);
        while (sa !== v) begin
            @(negedge clk);
            n++;
            if (n > 10) begin
                n_mismatch++;
                $display("[ERR] sleep exp %b got %b", v, sa);
                give_verdict();
            end
        end
        chk("sleep delay", 72'(exp_n), 72'(n));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        wr_burst(6'h05, 3'h1, 8'h00);
        rd_burst(6'h06, 1'b0);
        for (int l = 0; l < 8; l++) begin
            wr_burst(6'h04, 3'(l), ~(8'h01 << l));
            rd_burst(6'h07, 1'b0);
        end
        wr_burst(6'h04, 3'h6, 8'hFF);
        rd_burst(6'h05, 1'b1);
        lbo = 1'b0;
        repeat (4) cyc(1'b0, 1'b1, DES, '0);
        wr_burst(6'h0B, 3'h2, 8'h00);
        rd_burst(6'h09, 1'b0);
        lbo = 1'b1;
        oen = 1'b1;
        repeat (4) cyc(1'b0, 1'b1, DES, '0);
        rd_burst(6'h05, 1'b0);
        oen = 1'b0;
        foreach (bad[i]) begin
            cyc(1'b0, 1'b1, bad[i], 6'h05);
            for (int k = 0; k < 5; k++) begin
                cyc(1'b1, 1'b1, SEL, '0);
                if (k > 1) chk("deselect", 1'h0, oe);
            end
        end
        slp = 1'b1;
        wait_sa(1'b1);
        slp = 1'b0;
        wait_sa(1'b0);
        repeat (2) cyc(1'b0, 1'b1, DES, '0);
        rd_burst(6'h06, 1'b0);
        give_verdict();
    end
endmodule
